// File: bench/apm_host.sv
// Host model: single I/O or memory reads and I/O writes to the register block.
// Assumes one clock; requests start only after reset release.
`timescale 1ns/1ps
module apm_host
  import apm_pkg::*;
(
  // Clock
  input wire logic clk,
  // Host I/O access
  output logic [15:0] io_addr,
  output logic io_mem,
  output logic io_rd,
  output logic io_wr,
  output logic [1:0] io_size,
  output logic [31:0] io_wdata,
  input wire logic [31:0] io_rdata,
  input wire logic io_rvalid
);
  initial begin
    io_addr = 16'h0000;
    io_mem = 1'b0;
    io_rd = 1'b0;
    io_wr = 1'b0;
    io_size = SZ_NONE;
    io_wdata = 32'h0000_0000;
  end
  // Size as given, natural or not; released address and data show the inverse
  task automatic wr(input logic [15:0] a, input apm_size_t s, input logic [31:0] d);
    @(posedge clk);
    io_addr <= a;
    io_mem <= 1'b0;
    io_size <= s;
    io_wdata <= d;
    io_wr <= 1'b1;
    @(posedge clk);
    io_wr <= 1'b0;
    io_addr <= ~a;
    io_wdata <= ~d;
    io_size <= SZ_NONE;
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic m, input apm_size_t s, output logic [31:0] d);
    d = 32'hxxxx_xxxx;
    @(posedge clk);
    io_addr <= a;
    io_mem <= m;
    io_size <= s;
    io_rd <= 1'b1;
    @(posedge clk);
    io_rd <= 1'b0;
    io_addr <= ~a;
    io_size <= SZ_NONE;
    for (int i = 0; i < 4; i++) begin
      #1;
      if (io_rvalid === 1'b1) begin
        d = io_rdata;
        break;
      end
      @(posedge clk);
    end
  endtask : rd
endmodule : apm_host

// File: bench/test_apm_regs.sv
// Testbench: register, timer, throttle, command and event checks.
// Assumes the host model drives the I/O port of the block.
`timescale 1ns/1ps
module test_apm_regs
  import apm_pkg::*;
;
  localparam logic [10:0] BH = FIXED_SPACE_BASE_DEF[15:5];
  logic clk, rst_n, io_mem, io_rd, io_wr, io_rvalid, tmr_smi_en, smi_sts_clr;
  logic smi_top_sts, smi_lvl2_sts, sci_o, cpu_stop, c2_req, os_mode, hibernate_req, sleep_req;
  logic [15:0] io_addr;
  logic [1:0] io_size;
  logic [31:0] io_wdata, io_rdata;
  logic [7:0] gpio_in;
  logic [2:0] sleep_type;
  int failures = 0, checks = 0, cyc = 0, c2_cnt = 0, hib_cnt = 0, slp_cnt = 0;
  // ****************************************
  // Instances
  // ****************************************
  apm_regs #(.FIXED_SPACE_BASE(FIXED_SPACE_BASE_DEF)) dut (
    .clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_mem(io_mem), .io_rd(io_rd), .io_wr(io_wr),
    .io_size(io_size), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid),
    .tmr_smi_en(tmr_smi_en), .smi_sts_clr(smi_sts_clr), .gpio_in(gpio_in), .smi_top_sts(smi_top_sts),
    .smi_lvl2_sts(smi_lvl2_sts), .sci_o(sci_o), .cpu_stop(cpu_stop), .c2_req(c2_req), .os_mode(os_mode),
    .hibernate_req(hibernate_req), .sleep_req(sleep_req), .sleep_type(sleep_type));
  apm_host host (.clk(clk), .io_addr(io_addr), .io_mem(io_mem), .io_rd(io_rd), .io_wr(io_wr),
    .io_size(io_size), .io_wdata(io_wdata), .io_rdata(io_rdata), .io_rvalid(io_rvalid));
  // ****************************************
  // Clock, monitors and checks
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (c2_req === 1'b1) c2_cnt++;
    if (hibernate_req === 1'b1) hib_cnt++;
    if (sleep_req === 1'b1) slp_cnt++;
    if (cyc >= 20000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic cmp32(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : cmp32
  task automatic cmp1(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask : cmp1
  task automatic rdc(input logic [4:0] o, input apm_size_t s, input logic [31:0] e, input string n);
    logic [31:0] d;
    host.rd({BH, o}, 1'b0, s, d);
    cmp32(n, e, d);
  endtask : rdc
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : report_and_stop
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [31:0] d, t0, t1;
    logic [31:0] thr[4];
    int lo[4], hi[4], n;
    logic [7:0] cmd[3];
    thr = '{32'h0000_0017, 32'h0000_0014, 32'h0000_0010, 32'h0000_0007};
    lo = '{60, 320, 0, 0};
    hi = '{140, 480, 0, 0};
    cmd = '{CMD_OS_RELEASE, CMD_HIBERNATE, CMD_OS_TAKEOVER};
    rst_n = 1'b0;
    tmr_smi_en = 1'b1;
    smi_sts_clr = 1'b0;
    gpio_in = 8'h00;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    host.rd(TMR_IO_ADDR, 1'b0, SZ_DWORD, d);
    cmp1("timer_reset", 1'b1, d[31:24] === 8'h00 && d[23:0] >= TMR_RESET);
    host.wr(TMR_IO_ADDR, SZ_DWORD, 32'h0000_0000);
    host.rd(TMR_IO_ADDR, 1'b0, SZ_DWORD, d);
    cmp1("timer_read_only", 1'b1, d[23:0] >= TMR_RESET);
    rdc(OFF_THROTTLE, SZ_DWORD, 32'h0000_0000, "throttle_reset");
    rdc(OFF_CMD, SZ_BYTE, 32'h0000_0000, "cmd_reset");
    repeat (60) @(posedge clk);
    rdc(OFF_FIX_STS, SZ_WORD, 32'h0000_0001, "timer_flag");
    cmp1("smi_top", 1'b1, smi_top_sts);
    cmp1("smi_lvl2", 1'b1, smi_lvl2_sts);
    host.rd(TMR_IO_ADDR, 1'b0, SZ_DWORD, t0);
    repeat (2000) @(posedge clk);
    host.rd(TMR_MEM_OFF, 1'b1, SZ_DWORD, t1);
    cmp1("timer_rate", 1'b1, t1 - t0 >= 32'h0000_0163 && t1 - t0 <= 32'h0000_0169);
    host.wr({BH, OFF_FIX_STS}, SZ_WORD, 32'h0000_0000);
    rdc(OFF_FIX_STS, SZ_WORD, 32'h0000_0001, "flag_keep");
    host.wr({BH, OFF_FIX_STS}, SZ_WORD, 32'h0000_0001);
    rdc(OFF_FIX_STS, SZ_WORD, 32'h0000_0000, "flag_clear");
    @(posedge clk);
    smi_sts_clr <= 1'b1;
    @(posedge clk);
    smi_sts_clr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    cmp1("smi_clear", 1'b0, smi_top_sts | smi_lvl2_sts);
    @(posedge clk);
    tmr_smi_en <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (60) @(posedge clk);
    rdc(OFF_FIX_STS, SZ_WORD, 32'h0000_0001, "flag_after_reset");
    cmp1("smi_gated", 1'b0, smi_top_sts | smi_lvl2_sts);
    host.wr({BH, OFF_THROTTLE}, SZ_DWORD, 32'hFFFF_FFFF);
    rdc(OFF_THROTTLE, SZ_DWORD, 32'h0000_0017, "throttle_bits");
    for (int i = 0; i < 4; i++) begin
      host.wr({BH, OFF_THROTTLE}, SZ_DWORD, thr[i]);
      n = 0;
      repeat (800) begin
        @(posedge clk);
        #1;
        if (cpu_stop === 1'b1) n++;
      end
      cmp1("throttle_duty", 1'b1, n >= lo[i] && n <= hi[i]);
    end
    host.wr({BH, OFF_FIX_EN}, SZ_WORD, 32'h0000_FFFF);
    rdc(OFF_FIX_EN, SZ_WORD, 32'h0000_0721, "fixed_mask");
    host.wr({BH, OFF_GPE_EN}, SZ_WORD, 32'h0000_FFFF);
    rdc(OFF_GPE_EN, SZ_WORD, 32'h0000_FFFF, "gp_mask");
    host.wr({BH, OFF_FIX_CTL}, SZ_WORD, 32'h0000_1C01);
    rdc(OFF_FIX_CTL, SZ_WORD, 32'h0000_1C01, "control_word");
    cmp32("sleep_type", 32'h0000_0007, {29'h000_0000, sleep_type});
    host.wr({BH, OFF_FIX_CTL}, SZ_WORD, 32'h0000_3C01);
    rdc(OFF_FIX_CTL, SZ_WORD, 32'h0000_1C01, "sleep_bit_reads_zero");
    cmp32("sleep_pulses", 32'h0000_0001, 32'(slp_cnt));
    rdc(OFF_C2, SZ_BYTE, 32'h0000_0000, "c2_read");
    host.wr({BH, OFF_C2}, SZ_BYTE, 32'h0000_00FF);
    rdc(OFF_C2, SZ_BYTE, 32'h0000_0000, "c2_after_write");
    @(posedge clk);
    #1;
    cmp32("c2_pulses", 32'h0000_0002, 32'(c2_cnt));
    rdc(OFF_RSVD5, SZ_BYTE, 32'h0000_0000, "no_c3");
    for (int i = 0; i < 3; i++) begin
      host.wr({BH, OFF_CMD}, SZ_BYTE, {24'h00_0000, cmd[i]});
      repeat (2) @(posedge clk);
      #1;
      cmp1("os_mode", i == 2, os_mode);
      rdc(OFF_CMD, SZ_BYTE, {24'h00_0000, cmd[i]}, "cmd_read");
    end
    cmp32("hibernate", 32'h0000_0001, 32'(hib_cnt));
    host.wr({BH, OFF_CMD}, SZ_WORD, 32'h0000_0002);
    rdc(OFF_CMD, SZ_BYTE, 32'h0000_0001, "wrong_size_write");
    cmp1("os_mode_kept", 1'b1, os_mode);
    rdc(OFF_CMD, SZ_WORD, 32'h0000_0000, "wrong_size");
    host.wr({BH, OFF_FIX_EN}, SZ_WORD, 32'h0000_0000);
    host.wr({BH, OFF_GPE_EN}, SZ_WORD, 32'h0000_0000);
    host.wr({BH, OFF_SETUP_INDEX}, SZ_WORD, 32'h0000_0010);
    host.wr({BH, OFF_SETUP_DATA}, SZ_WORD, 32'h0000_0033);
    @(posedge clk);
    gpio_in <= 8'h01;
    repeat (8) @(posedge clk);
    rdc(OFF_GPE_STS, SZ_WORD, 32'h0000_0008, "gp_flag");
    cmp1("sci_masked", 1'b0, sci_o);
    host.wr({BH, OFF_GPE_EN}, SZ_WORD, 32'h0000_0008);
    repeat (3) @(posedge clk);
    #1;
    cmp1("sci_on", 1'b1, sci_o);
    host.wr({BH, OFF_GPE_STS}, SZ_WORD, 32'h0000_0008);
    repeat (3) @(posedge clk);
    #1;
    cmp1("sci_off", 1'b0, sci_o);
    report_and_stop();
  end
endmodule : test_apm_regs

// File: rtl/apm_pkg.sv
// Constants for the power-management timer and fixed-feature register block.
// Assumes a 20 MHz system clock and a host that issues single I/O accesses.
package apm_pkg;
  // ****************************************
  // Address map
  // ****************************************
  localparam logic [15:0] FIXED_SPACE_BASE_DEF = 16'hAC00;
  localparam logic [15:0] TMR_IO_ADDR = 16'h121C;
  localparam logic [15:0] TMR_MEM_OFF = 16'h001C;
  localparam logic [4:0] OFF_THROTTLE = 5'h00;
  localparam logic [4:0] OFF_C2 = 5'h04;
  localparam logic [4:0] OFF_RSVD5 = 5'h05;
  localparam logic [4:0] OFF_CMD = 5'h06;
  localparam logic [4:0] OFF_RSVD7 = 5'h07;
  localparam logic [4:0] OFF_FIX_STS = 5'h08;
  localparam logic [4:0] OFF_FIX_EN = 5'h0A;
  localparam logic [4:0] OFF_FIX_CTL = 5'h0C;
  localparam logic [4:0] OFF_SETUP_INDEX = 5'h0E;
  localparam logic [4:0] OFF_GPE_STS = 5'h10;
  localparam logic [4:0] OFF_GPE_EN = 5'h12;
  localparam logic [4:0] OFF_SETUP_DATA = 5'h14;
  // ****************************************
  // Access sizes
  // ****************************************
  typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_DWORD = 2'h2, SZ_NONE = 2'h3} apm_size_t;
  // ****************************************
  // Fields, masks and reset values
  // ****************************************
  localparam logic [23:0] TMR_RESET = 24'hFF_FFFC;
  localparam logic [31:0] THR_MASK = 32'h0000_0017;
  localparam int THR_ON_BIT = 4;
  localparam logic [15:0] FIX_STS_MASK = 16'h8721;
  localparam logic [15:0] FIX_EN_MASK = 16'h0721;
  localparam int FIX_TMR_BIT = 0;
  localparam logic [15:0] CTL_MASK = 16'h1C01;
  localparam int CTL_SCI_EN = 0;
  localparam int CTL_SLP_EN = 13;
  localparam int CTL_SLP_TYP_LSB = 10;
  localparam logic [12:0] SETUP_MAP_PAGE = 13'h0002;
  localparam int MAP_N = 8;
  // ****************************************
  // Commands and timing
  // ****************************************
  localparam logic [7:0] CMD_OS_TAKEOVER = 8'h01;
  localparam logic [7:0] CMD_OS_RELEASE = 8'h02;
  localparam logic [7:0] CMD_HIBERNATE = 8'h03;
  localparam int CLK_HZ = 20_000_000;
  localparam int TMR_HZ = 3_579_545;
  localparam logic [24:0] ACC_STEP = 25'(TMR_HZ);
  localparam logic [24:0] ACC_MOD = 25'(CLK_HZ);
endpackage : apm_pkg

// File: rtl/apm_regs.sv
// Power-management timer, throttle, C2 trigger, command port and event groups.
// Assumes a host issuing one-cycle I/O read/write strobes on clk.
`timescale 1ns/1ps
module apm_regs
  import apm_pkg::*;
#(
  parameter logic [15:0] FIXED_SPACE_BASE = FIXED_SPACE_BASE_DEF
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Host I/O access
  input wire logic [15:0] io_addr,
  input wire logic io_mem,
  input wire logic io_rd,
  input wire logic io_wr,
  input wire logic [1:0] io_size,
  input wire logic [31:0] io_wdata,
  output logic [31:0] io_rdata,
  output logic io_rvalid,
  // Side-band inputs
  input wire logic tmr_smi_en,
  input wire logic smi_sts_clr,
  input wire logic [7:0] gpio_in,
  // Power-management outputs
  output logic smi_top_sts,
  output logic smi_lvl2_sts,
  output logic sci_o,
  output logic cpu_stop,
  output logic c2_req,
  output logic os_mode,
  output logic hibernate_req,
  output logic sleep_req,
  output logic [2:0] sleep_type
);
  // ****************************************
  // Decode
  // ****************************************
  function automatic logic [1:0] nat_size(input logic [4:0] o);
    case (o)
      OFF_THROTTLE: nat_size = SZ_DWORD;
      OFF_C2, OFF_RSVD5, OFF_CMD, OFF_RSVD7: nat_size = SZ_BYTE;
      OFF_FIX_STS, OFF_FIX_EN, OFF_FIX_CTL, OFF_SETUP_INDEX: nat_size = SZ_WORD;
      OFF_GPE_STS, OFF_GPE_EN, OFF_SETUP_DATA: nat_size = SZ_WORD;
      default: nat_size = SZ_NONE;
    endcase
  endfunction : nat_size

  logic hit_blk;
  logic hit_tmr;
  logic [4:0] off;
  logic rd_ok;
  logic wr_ok;
  assign off = io_addr[4:0];
  assign hit_blk = !io_mem && (io_addr[15:5] == FIXED_SPACE_BASE[15:5]);
  assign hit_tmr = (io_mem ? io_addr == TMR_MEM_OFF : io_addr == TMR_IO_ADDR) && io_size == SZ_DWORD;
  assign rd_ok = io_rd && hit_blk && io_size == nat_size(off);
  assign wr_ok = io_wr && hit_blk && io_size == nat_size(off);

  // ****************************************
  // Timer
  // ****************************************
  logic [24:0] acc_r, acc_nxt;
  logic [23:0] cnt_r, cnt_nxt;
  logic [24:0] acc_sum;
  logic tick;
  logic tog;
  always_comb begin
    acc_sum = acc_r + ACC_STEP;
    tick = acc_sum >= ACC_MOD;
    acc_nxt = tick ? acc_sum - ACC_MOD : acc_sum;
    cnt_nxt = cnt_r + 24'(tick);
    tog = tick && (cnt_nxt[23] != cnt_r[23]);
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_r <= '0;
      cnt_r <= TMR_RESET;
    end else begin
      acc_r <= acc_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ****************************************
  // GPIO synchroniser
  // ****************************************
  logic [7:0] g1_r, g2_r, g3_r;
  logic [7:0] rise;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      g1_r <= '0;
      g2_r <= '0;
      g3_r <= '0;
    end else begin
      g1_r <= gpio_in;
      g2_r <= g1_r;
      g3_r <= g2_r;
    end
  end
  assign rise = g2_r & ~g3_r;

  // ****************************************
  // Registers
  // ****************************************
  logic [31:0] thr_r, thr_nxt;
  logic [7:0] cmd_r, cmd_nxt;
  logic [15:0] fsts_r, fsts_nxt, fen_r, fen_nxt, ctl_r, ctl_nxt, idx_r, idx_nxt;
  logic [15:0] gsts_r, gsts_nxt, gen_r, gen_nxt;
  logic [5:0] map_r [MAP_N];
  logic [5:0] map_nxt [MAP_N];
  logic smi_top_r, smi_top_nxt, smi_l2_r, smi_l2_nxt;
  logic [15:0] fset, gset, wclr;
  logic idx_ok;
  always_comb begin
    fset = '0;
    gset = '0;
    fset[FIX_TMR_BIT] = tog;
    for (int n = 0; n < MAP_N; n++) begin
      if (rise[n] && map_r[n][5]) begin
        if (map_r[n][4]) begin
          gset[map_r[n][3:0]] = 1'b1;
        end else begin
          fset[map_r[n][3:0]] = 1'b1;
        end
      end
    end
    fset = fset & FIX_STS_MASK;
    idx_ok = idx_r[15:3] == SETUP_MAP_PAGE;
    wclr = io_wdata[15:0];
    thr_nxt = thr_r;
    cmd_nxt = cmd_r;
    fen_nxt = fen_r;
    ctl_nxt = ctl_r;
    idx_nxt = idx_r;
    gen_nxt = gen_r;
    map_nxt = map_r;
    fsts_nxt = fsts_r;
    gsts_nxt = gsts_r;
    if (wr_ok) begin
      case (off)
        OFF_THROTTLE: thr_nxt = io_wdata & THR_MASK;
        OFF_CMD: begin
          cmd_nxt = io_wdata[7:0];
          if (io_wdata[7:0] == CMD_OS_TAKEOVER) begin
            ctl_nxt[CTL_SCI_EN] = 1'b1;
          end else if (io_wdata[7:0] == CMD_OS_RELEASE) begin
            ctl_nxt[CTL_SCI_EN] = 1'b0;
          end
        end
        OFF_FIX_STS: fsts_nxt = fsts_r & ~wclr;
        OFF_FIX_EN: fen_nxt = wclr & FIX_EN_MASK;
        OFF_FIX_CTL: ctl_nxt = wclr & CTL_MASK;
        OFF_SETUP_INDEX: if (wclr[15:3] == SETUP_MAP_PAGE) idx_nxt = wclr;
        OFF_GPE_STS: gsts_nxt = gsts_r & ~wclr;
        OFF_GPE_EN: gen_nxt = wclr;
        OFF_SETUP_DATA: if (idx_ok) map_nxt[idx_r[2:0]] = io_wdata[5:0];
        default: ;
      endcase
    end
    fsts_nxt = fsts_nxt | fset;
    gsts_nxt = gsts_nxt | gset;
    smi_top_nxt = (smi_top_r && !smi_sts_clr) || (tog && tmr_smi_en);
    smi_l2_nxt = (smi_l2_r && !smi_sts_clr) || (tog && tmr_smi_en);
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thr_r <= '0;
      cmd_r <= '0;
      fsts_r <= '0;
      fen_r <= '0;
      ctl_r <= '0;
      idx_r <= '0;
      gsts_r <= '0;
      gen_r <= '0;
      smi_top_r <= 1'b0;
      smi_l2_r <= 1'b0;
      for (int n = 0; n < MAP_N; n++) begin
        map_r[n] <= '0;
      end
    end else begin
      thr_r <= thr_nxt;
      cmd_r <= cmd_nxt;
      fsts_r <= fsts_nxt;
      fen_r <= fen_nxt;
      ctl_r <= ctl_nxt;
      idx_r <= idx_nxt;
      gsts_r <= gsts_nxt;
      gen_r <= gen_nxt;
      smi_top_r <= smi_top_nxt;
      smi_l2_r <= smi_l2_nxt;
      map_r <= map_nxt;
    end
  end

  // ****************************************
  // Read data and output strobes
  // ****************************************
  logic [31:0] rdata_r, rdata_nxt;
  logic rvalid_r, c2_r, c2_nxt, hib_r, hib_nxt, slp_r, slp_nxt;
  logic sci_r, sci_nxt, stop_r, stop_nxt;
  logic [2:0] phase_r, phase_nxt;
  logic [2:0] duty;
  always_comb begin
    rdata_nxt = '0;
    if (io_rd && hit_tmr) begin
      rdata_nxt = {8'h00, cnt_r};
    end else if (rd_ok) begin
      case (off)
        OFF_THROTTLE: rdata_nxt = thr_r;
        OFF_CMD: rdata_nxt = {24'h00_0000, cmd_r};
        OFF_FIX_STS: rdata_nxt = {16'h0000, fsts_r};
        OFF_FIX_EN: rdata_nxt = {16'h0000, fen_r};
        OFF_FIX_CTL: rdata_nxt = {16'h0000, ctl_r};
        OFF_SETUP_INDEX: rdata_nxt = {16'h0000, idx_r};
        OFF_GPE_STS: rdata_nxt = {16'h0000, gsts_r};
        OFF_GPE_EN: rdata_nxt = {16'h0000, gen_r};
        OFF_SETUP_DATA: if (idx_ok) rdata_nxt = {26'h00_0000, map_r[idx_r[2:0]]};
        default: rdata_nxt = '0;
      endcase
    end
    c2_nxt = rd_ok && off == OFF_C2;
    hib_nxt = wr_ok && off == OFF_CMD && io_wdata[7:0] == CMD_HIBERNATE;
    slp_nxt = wr_ok && off == OFF_FIX_CTL && io_wdata[CTL_SLP_EN];
    sci_nxt = ctl_r[CTL_SCI_EN] && ((|(fsts_r & fen_r)) || (|(gsts_r & gen_r)));
    duty = thr_r[2:0];
    phase_nxt = phase_r + 3'(tick);
    stop_nxt = thr_r[THR_ON_BIT] && duty != 3'h0 && phase_r >= duty;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= '0;
      rvalid_r <= 1'b0;
      c2_r <= 1'b0;
      hib_r <= 1'b0;
      slp_r <= 1'b0;
      sci_r <= 1'b0;
      stop_r <= 1'b0;
      phase_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= io_rd;
      c2_r <= c2_nxt;
      hib_r <= hib_nxt;
      slp_r <= slp_nxt;
      sci_r <= sci_nxt;
      stop_r <= stop_nxt;
      phase_r <= phase_nxt;
    end
  end
  assign io_rdata = rdata_r;
  assign io_rvalid = rvalid_r;
  assign smi_top_sts = smi_top_r;
  assign smi_lvl2_sts = smi_l2_r;
  assign sci_o = sci_r;
  assign cpu_stop = stop_r;
  assign c2_req = c2_r;
  assign os_mode = ctl_r[CTL_SCI_EN];
  assign hibernate_req = hib_r;
  assign sleep_req = slp_r;
  assign sleep_type = ctl_r[CTL_SLP_TYP_LSB +: 3];

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_count_hold: assert property (!tick |=> cnt_r == $past(cnt_r))
    else $error("Timer moved without a tick");
  chk_count_step: assert property (tick |=> cnt_r == 24'($past(cnt_r) + 24'h00_0001))
    else $error("Timer did not step by one");
  chk_tmr_read: assert property (io_rd && hit_tmr |=> io_rvalid && io_rdata == {8'h00, $past(cnt_r)})
    else $error("Timer read value wrong");
  chk_smi_raise: assert property (tog && tmr_smi_en |=> smi_top_sts && smi_lvl2_sts)
    else $error("Timer SMI not reported");
  chk_tmr_flag: assert property (tog |=> fsts_r[FIX_TMR_BIT])
    else $error("Timer flag not set on toggle");
  chk_c2_read: assert property (rd_ok && off == OFF_C2 |=> c2_req && io_rdata == 32'h0000_0000)
    else $error("C2 read misbehaved");
  chk_cmd_takeover: assert property (wr_ok && off == OFF_CMD && io_wdata[7:0] == CMD_OS_TAKEOVER |=> os_mode ##1 1'b1)
    else $error("Takeover command ignored");
  chk_sci_gate: assert property (!ctl_r[CTL_SCI_EN] || !(|(gsts_r & gen_r) || |(fsts_r & fen_r)) |=> !sci_o)
    else $error("SCI raised without enabled event");
  chk_flag_clear: assert property (wr_ok && off == OFF_GPE_STS && io_wdata[0] && !gset[0] |=> !gsts_r[0])
    else $error("Write one did not clear flag");
  chk_throttle_off: assert property (!thr_r[THR_ON_BIT] |=> !cpu_stop)
    else $error("Clock stopped while throttle off");
endmodule : apm_regs
